/* File: core/sss_params.svh */
`ifndef SSS_PARAMS_SVH
`define SSS_PARAMS_SVH

// control clock and the millisecond time base for mains-loss detection
`define SSS_CLK_PERIOD_NS 25
`define SSS_MS_NS         1000000
`define SSS_CYC_PER_MS    (`SSS_MS_NS / `SSS_CLK_PERIOD_NS)

// stop threshold in r/min
`define SSS_STOP_RPM      30

// mains-loss hold time limits in ms
`define SSS_HOLD_MIN      11'h046
`define SSS_HOLD_OFF      11'h7d0

// field positions inside a stop selection code
`define SSS_BIT_DECEL     0
`define SSS_BIT_AFTER     1
`define SSS_BIT_HOLD      2

// selection codes with immediate stop
`define SSS_SEL_IMM_DB    4'h8
`define SSS_SEL_IMM_FREE  4'h9

// torque limit value that means the normal limit applies
`define SSS_TLIM_NORMAL   10'h000

`endif

/* File: core/sss_pkg.sv */
package sss_pkg;

    typedef enum logic [1:0] {
        SSS_PH_RUN,
        SSS_PH_DECEL,
        SSS_PH_AFTER
    } sss_phase_t;

    typedef enum logic [1:0] {
        SSS_ACT_RUN,
        SSS_ACT_DB,
        SSS_ACT_FREE,
        SSS_ACT_IMM
    } sss_act_t;

    typedef enum logic [1:0] {
        SSS_CAUSE_NONE,
        SSS_CAUSE_SOFF,
        SSS_CAUSE_MAINS,
        SSS_CAUSE_FAULT
    } sss_cause_t;

    typedef struct packed {
        sss_act_t decel;
        sss_act_t after;
        logic     clr;
    } sss_plan_t;

    typedef struct packed {
        logic [3:0]  servo_off_stop_select;
        logic [3:0]  mains_off_stop_select;
        logic        undervoltage_trip_select;
        logic [10:0] mains_loss_hold_time;
        logic [2:0]  fault_stop_select;
        logic [9:0]  immediate_stop_torque_limit;
    } sss_cfg_t;

    typedef struct packed {
        sss_act_t   act;
        sss_phase_t phase;
        logic       servo_loop;
        logic       torque_lim_en;
        logic [9:0] torque_lim;
        logic       pos_err_clear;
        logic       ext_err_clear;
        logic       err_hold;
    } sss_drive_t;

endpackage : sss_pkg

/* File: core/sss_selector.sv */
`include "sss_params.svh"

module sss_selector #(
    parameter int P_CYC_PER_MS = `SSS_CYC_PER_MS,
    parameter int P_SPEED_W    = 16,
    parameter int P_ERR_W      = 28
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    input  wire logic                 i_servo_on,
    input  wire logic                 i_mains_ok,
    input  wire logic                 i_alarm,
    input  wire logic                 i_alarm_imm_ok,
    input  wire logic                 i_alarm_reset,
    input  wire logic [P_SPEED_W-1:0] i_speed_abs,
    input  wire logic [P_ERR_W-1:0]   i_pos_err_abs,
    input  wire logic [P_ERR_W-1:0]   i_err_limit,
    input  sss_pkg::sss_cfg_t         i_cfg,
    output sss_pkg::sss_drive_t       o_drive,
    output logic                      o_alarm,
    output logic                      o_uv_alarm,
    output logic                      o_overflow_alarm,
    output logic                      o_mains_lost
);

    typedef struct packed {
        logic                 mains_s1;
        logic                 mains_s2;
        logic [15:0]          cyc_cnt;
        logic [10:0]          loss_ms;
        logic                 mains_lost;
        logic                 alarm;
        logic                 imm_ok;
        logic                 uv_alarm;
        logic                 ovf_alarm;
        sss_pkg::sss_cause_t  cause;
        sss_pkg::sss_drive_t  drive;
    } sss_state_t;

    sss_state_t          q;
    sss_state_t          d;
    logic                tick;
    logic [10:0]         hold;
    logic                new_loss;
    logic                uv_set;
    logic                ovf_set;
    logic                alarm_set;
    logic                alarm_clr;
    logic                slow;
    sss_pkg::sss_plan_t  plan;

    // decode of a ten-value stop selection
    function automatic sss_pkg::sss_plan_t plan_std(input logic [3:0] sel);
        sss_pkg::sss_plan_t p;
        p.decel = sss_pkg::SSS_ACT_DB;
        p.after = sss_pkg::SSS_ACT_DB;
        p.clr   = 1'b1;
        if (sel == `SSS_SEL_IMM_DB || sel == `SSS_SEL_IMM_FREE) begin
            p.decel = sss_pkg::SSS_ACT_IMM;
            if (sel == `SSS_SEL_IMM_FREE) begin
                p.after = sss_pkg::SSS_ACT_FREE;
            end
        end else if (sel < `SSS_SEL_IMM_DB) begin
            if (sel[`SSS_BIT_DECEL]) begin
                p.decel = sss_pkg::SSS_ACT_FREE;
            end
            if (sel[`SSS_BIT_AFTER]) begin
                p.after = sss_pkg::SSS_ACT_FREE;
            end
            p.clr = ~sel[`SSS_BIT_HOLD];
        end
        return p;
    endfunction

    // decode of the alarm stop selection
    function automatic sss_pkg::sss_plan_t plan_fault(input logic [2:0] sel,
                                                      input logic       imm);
        sss_pkg::sss_plan_t p;
        p = plan_std({2'h0, sel[1:0]});
        p.clr = 1'b0;
        if (sel[`SSS_BIT_HOLD] && imm) begin
            p.decel = sss_pkg::SSS_ACT_IMM;
        end
        return p;
    endfunction

    always_comb begin
        d         = q;
        tick      = 1'b0;
        new_loss  = 1'b0;
        uv_set    = 1'b0;
        ovf_set   = 1'b0;
        alarm_set = 1'b0;
        alarm_clr = 1'b0;
        slow      = 1'b0;
        plan      = plan_std(4'h0);
        hold      = i_cfg.mains_loss_hold_time;

        if (hold < `SSS_HOLD_MIN) begin
            hold = `SSS_HOLD_MIN;
        end

        d.mains_s1 = i_mains_ok;
        d.mains_s2 = q.mains_s1;

        // millisecond time base
        if (q.cyc_cnt == 16'(P_CYC_PER_MS - 1)) begin
            d.cyc_cnt = 16'h0000;
            tick      = 1'b1;
        end else begin
            d.cyc_cnt = q.cyc_cnt + 16'h0001;
        end

        // mains loss detection
        if (q.mains_s2 || hold >= `SSS_HOLD_OFF) begin
            d.loss_ms    = 11'h000;
            d.mains_lost = 1'b0;
        end else if (tick && !q.mains_lost) begin
            if (q.loss_ms + 11'h001 >= hold) begin
                d.mains_lost = 1'b1;
            end else begin
                d.loss_ms = q.loss_ms + 11'h001;
            end
        end
        new_loss = d.mains_lost && !q.mains_lost;

        // undervoltage trip while the servo is on
        if (new_loss && i_servo_on && i_cfg.undervoltage_trip_select
                && q.cause == sss_pkg::SSS_CAUSE_NONE) begin
            uv_set = 1'b1;
        end

        // held error growing during a stop
        if (q.drive.err_hold && i_pos_err_abs > i_err_limit) begin
            ovf_set = 1'b1;
        end

        alarm_set = i_alarm || uv_set || ovf_set;
        alarm_clr = i_alarm_reset && !alarm_set;

        if (alarm_set) begin
            if (!q.alarm) begin
                d.imm_ok = i_alarm && i_alarm_imm_ok;
            end
            d.alarm = 1'b1;
        end else if (alarm_clr) begin
            d.alarm  = 1'b0;
            d.imm_ok = 1'b0;
        end

        if (uv_set) begin
            d.uv_alarm = 1'b1;
        end else if (alarm_clr) begin
            d.uv_alarm = 1'b0;
        end

        if (ovf_set) begin
            d.ovf_alarm = 1'b1;
        end else if (alarm_clr) begin
            d.ovf_alarm = 1'b0;
        end

        // cause priority: alarm, then mains, then servo off
        if (d.alarm) begin
            d.cause = sss_pkg::SSS_CAUSE_FAULT;
        end else if (d.mains_lost) begin
            d.cause = sss_pkg::SSS_CAUSE_MAINS;
        end else if (!i_servo_on) begin
            d.cause = sss_pkg::SSS_CAUSE_SOFF;
        end else begin
            d.cause = sss_pkg::SSS_CAUSE_NONE;
        end

        case (d.cause)
            sss_pkg::SSS_CAUSE_FAULT: begin
                plan = plan_fault(i_cfg.fault_stop_select, d.imm_ok);
            end
            sss_pkg::SSS_CAUSE_MAINS: begin
                plan = plan_std(i_cfg.mains_off_stop_select);
            end
            sss_pkg::SSS_CAUSE_SOFF: begin
                plan = plan_std(i_cfg.servo_off_stop_select);
            end
            default: begin
                plan = plan_std(4'h0);
            end
        endcase

        // stop phase sequencing
        slow = i_speed_abs <= P_SPEED_W'(`SSS_STOP_RPM);
        case (q.drive.phase)
            sss_pkg::SSS_PH_RUN: begin
                if (d.cause != sss_pkg::SSS_CAUSE_NONE) begin
                    d.drive.phase = sss_pkg::SSS_PH_DECEL;
                end
            end
            sss_pkg::SSS_PH_DECEL: begin
                if (d.cause == sss_pkg::SSS_CAUSE_NONE) begin
                    d.drive.phase = sss_pkg::SSS_PH_RUN;
                end else if (d.cause != q.cause) begin
                    d.drive.phase = sss_pkg::SSS_PH_DECEL;
                end else if (slow) begin
                    d.drive.phase = sss_pkg::SSS_PH_AFTER;
                end
            end
            sss_pkg::SSS_PH_AFTER: begin
                if (d.cause == sss_pkg::SSS_CAUSE_NONE) begin
                    d.drive.phase = sss_pkg::SSS_PH_RUN;
                end else if (d.cause != q.cause) begin
                    d.drive.phase = sss_pkg::SSS_PH_DECEL;
                end
            end
            default: begin
                d.drive.phase = sss_pkg::SSS_PH_RUN;
            end
        endcase

        // power stage action for the phase
        case (d.drive.phase)
            sss_pkg::SSS_PH_DECEL: begin
                d.drive.act = plan.decel;
            end
            sss_pkg::SSS_PH_AFTER: begin
                d.drive.act = plan.after;
            end
            default: begin
                d.drive.act = sss_pkg::SSS_ACT_RUN;
            end
        endcase

        d.drive.servo_loop = d.drive.act == sss_pkg::SSS_ACT_RUN
                          || d.drive.act == sss_pkg::SSS_ACT_IMM;
        d.drive.torque_lim_en = d.drive.act == sss_pkg::SSS_ACT_IMM
            && i_cfg.immediate_stop_torque_limit != `SSS_TLIM_NORMAL;
        d.drive.torque_lim = i_cfg.immediate_stop_torque_limit;

        // error counter treatment
        d.drive.pos_err_clear = 1'b0;
        d.drive.err_hold      = 1'b0;
        if (d.drive.phase != sss_pkg::SSS_PH_RUN) begin
            if (d.cause == sss_pkg::SSS_CAUSE_FAULT) begin
                d.drive.err_hold = 1'b1;
            end else if (plan.clr) begin
                d.drive.pos_err_clear = 1'b1;
            end else begin
                d.drive.err_hold = 1'b1;
            end
        end
        if (alarm_clr && q.alarm) begin
            d.drive.pos_err_clear = 1'b1;
            d.drive.err_hold      = 1'b0;
        end
        d.drive.ext_err_clear = d.drive.pos_err_clear;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q.mains_s1    <= 1'b1;
            q.mains_s2    <= 1'b1;
            q.cyc_cnt     <= 16'h0000;
            q.loss_ms     <= 11'h000;
            q.mains_lost  <= 1'b0;
            q.alarm       <= 1'b0;
            q.imm_ok      <= 1'b0;
            q.uv_alarm    <= 1'b0;
            q.ovf_alarm   <= 1'b0;
            q.cause       <= sss_pkg::SSS_CAUSE_NONE;
            q.drive       <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_drive          = q.drive;
    assign o_alarm          = q.alarm;
    assign o_uv_alarm       = q.uv_alarm;
    assign o_overflow_alarm = q.ovf_alarm;
    assign o_mains_lost     = q.mains_lost;

endmodule // sss_selector

/* File: bench/sss_motor.sv */
module sss_motor (
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    input  sss_pkg::sss_drive_t i_drive,
    input  wire logic [15:0]   i_cmd,
    input  wire logic          i_push,
    output logic [15:0]        o_speed
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] dec;
    logic [15:0] speed_q;
    assign o_speed = speed_q;
    always_comb begin
        case (i_drive.act)
            sss_pkg::SSS_ACT_DB:  dec = 16'h0004;
            sss_pkg::SSS_ACT_IMM: dec = 16'h0010;
            default:              dec = 16'h0001;
        endcase
    end
    // a load push or a running drive sets the commanded speed
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            speed_q <= 16'h0000;
        end else if (i_push || i_drive.act == sss_pkg::SSS_ACT_RUN) begin
            speed_q <= i_cmd;
        end else begin
            speed_q <= (speed_q > dec) ? speed_q - dec : 16'h0000;
        end
    end
endmodule // sss_motor

/* File: bench/sss_selector_properties.sv */
module sss_chk #(
    parameter int P_CYC_PER_MS = 10,
    parameter int P_SPEED_W    = 16
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    input  wire logic                 i_servo_on,
    input  wire logic                 i_mains_ok,
    input  wire logic                 i_alarm,
    input  wire logic [P_SPEED_W-1:0] i_speed_abs,
    input  sss_pkg::sss_cfg_t         i_cfg,
    input  sss_pkg::sss_drive_t       o_drive,
    input  wire logic                 o_alarm,
    input  wire logic                 o_uv_alarm,
    input  wire logic                 o_mains_lost
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic soff;
    int   lo_q;
    assign soff = !i_servo_on && !i_alarm && !o_alarm && !o_mains_lost;
    always_ff @(posedge i_clk) begin
        lo_q <= (i_rst || i_mains_ok) ? 0 : lo_q + 1;
    end
    property p_imm;
        o_drive.act == sss_pkg::SSS_ACT_IMM && $stable(i_cfg) |-> o_drive.servo_loop
            && o_drive.torque_lim_en == (i_cfg.immediate_stop_torque_limit != 10'h000);
    endproperty
    property p_clr;
        o_drive.pos_err_clear == o_drive.ext_err_clear
            && !(o_drive.pos_err_clear && o_drive.err_hold);
    endproperty
    property p_dec;
        o_drive.phase == sss_pkg::SSS_PH_DECEL && soff && i_speed_abs > 16'h001e
            |=> o_drive.phase == sss_pkg::SSS_PH_DECEL || o_alarm || o_mains_lost;
    endproperty
    property p_aft;
        o_drive.phase == sss_pkg::SSS_PH_AFTER && soff
            |=> o_drive.phase == sss_pkg::SSS_PH_AFTER || o_alarm || o_mains_lost;
    endproperty
    property p_sel;
        o_drive.phase != sss_pkg::SSS_PH_RUN && soff && !$past(o_alarm) && $stable(i_cfg)
            |-> o_drive.err_hold == (i_cfg.servo_off_stop_select inside {[4'h4:4'h7]});
    endproperty
    property p_flt;
        o_alarm && o_drive.phase == sss_pkg::SSS_PH_DECEL && $stable(i_cfg)
            && i_cfg.fault_stop_select < 3'h4 |-> o_drive.act == (i_cfg.fault_stop_select[0]
            ? sss_pkg::SSS_ACT_FREE : sss_pkg::SSS_ACT_DB);
    endproperty
    property p_uv;
        $rose(o_uv_alarm) |-> o_alarm && o_mains_lost && i_cfg.undervoltage_trip_select;
    endproperty
    property p_rst;
        $fell(o_alarm) |-> o_drive.pos_err_clear;
    endproperty
    property p_off;
        $rose(o_mains_lost) |-> i_cfg.mains_loss_hold_time < 11'h7d0;
    endproperty
    property p_det;
        $rose(o_mains_lost) |-> lo_q >= (int'(i_cfg.mains_loss_hold_time) - 1) * P_CYC_PER_MS;
    endproperty
    a_imm: assert property (p_imm) else $error("immediate stop loop or limit");
    a_clr: assert property (p_clr) else $error("error clears differ");
    a_dec: assert property (p_dec) else $error("left deceleration early");
    a_aft: assert property (p_aft) else $error("left after-stop phase");
    a_sel: assert property (p_sel) else $error("servo-off hold wrong");
    a_flt: assert property (p_flt) else $error("alarm decel action wrong");
    a_uv: assert property (p_uv) else $error("undervoltage alarm alone");
    a_rst: assert property (p_rst) else $error("no clear on alarm reset");
    a_off: assert property (p_off) else $error("detection not disabled");
    a_det: assert property (p_det) else $error("mains loss seen early");
    c_imm: cover property (o_drive.act == sss_pkg::SSS_ACT_IMM);
    c_uv: cover property ($rose(o_uv_alarm));
    c_aft: cover property (o_drive.phase == sss_pkg::SSS_PH_AFTER && o_alarm);
endmodule // sss_chk

bind sss_selector sss_chk #(.P_CYC_PER_MS(P_CYC_PER_MS), .P_SPEED_W(P_SPEED_W)) u_chk (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_servo_on   (i_servo_on),
    .i_mains_ok   (i_mains_ok),
    .i_alarm      (i_alarm),
    .i_speed_abs  (i_speed_abs),
    .i_cfg        (i_cfg),
    .o_drive      (o_drive),
    .o_alarm      (o_alarm),
    .o_uv_alarm   (o_uv_alarm),
    .o_mains_lost (o_mains_lost)
);

/* File: bench/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam sss_pkg::sss_act_t RUN = sss_pkg::SSS_ACT_RUN, DB = sss_pkg::SSS_ACT_DB;
    localparam sss_pkg::sss_act_t FR = sss_pkg::SSS_ACT_FREE, IM = sss_pkg::SSS_ACT_IMM;
    localparam sss_pkg::sss_phase_t PR = sss_pkg::SSS_PH_RUN, PD = sss_pkg::SSS_PH_DECEL;
    localparam sss_pkg::sss_phase_t PA = sss_pkg::SSS_PH_AFTER;
    logic                i_clk, i_rst, son, mok, alm, imm, arst, push;
    logic                oalm, ouv, oov, olost;
    logic [15:0]         spd, cmd;
    logic [27:0]         lim;
    sss_pkg::sss_cfg_t   cfg;
    sss_pkg::sss_drive_t drv;
    int                  n_errors = 0, total_checks = 0, n;

    sss_selector #(.P_CYC_PER_MS(10)) u_dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_servo_on(son), .i_mains_ok(mok), .i_alarm(alm), .i_alarm_imm_ok(imm),
        .i_alarm_reset(arst), .i_speed_abs(spd), .i_pos_err_abs(28'h0000064),
        .i_err_limit(lim), .i_cfg(cfg), .o_drive(drv), .o_alarm(oalm), .o_uv_alarm(ouv),
        .o_overflow_alarm(oov), .o_mains_lost(olost));
    sss_motor u_mot (.i_clk(i_clk), .i_rst(i_rst), .i_drive(drv), .i_cmd(cmd),
        .i_push(push), .o_speed(spd));

    task automatic finish_test();
        if (n_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [18:0] s, e);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic nx(input int k);
        repeat (k) @(negedge i_clk);
    endtask
    task automatic cd(input sss_pkg::sss_act_t a, input sss_pkg::sss_phase_t p,
                      input logic c, h);
        chk(19'({drv.act, drv.phase, drv.servo_loop & (a != RUN), drv.pos_err_clear,
            drv.ext_err_clear, drv.err_hold}), 19'({a, p, a == IM, c, c, h}));
    endtask
    // waits for a phase; the speed seen just before the change must cross the threshold
    task automatic wph(input sss_pkg::sss_phase_t p);
        logic [15:0] a, b;
        a = spd;
        b = 16'hffff;
        n = 0;
        while (drv.phase !== p && n < 300) begin
            b = a;
            a = spd;
            nx(1);
            n++;
        end
        chk(19'({drv.phase, a <= 16'h001e, b > 16'h001e}), 19'({p, 2'b11}));
    endtask
    task automatic wl();
        n = 0;
        while (olost !== 1'b1 && n < 900) begin
            nx(1);
            n++;
        end
    endtask
    task automatic al(input logic v);
        @(posedge i_clk);
        alm <= 1;
        imm <= v;
        @(posedge i_clk) alm <= 0;
    endtask
    task automatic rs();
        @(posedge i_clk) arst <= 1;
        @(posedge i_clk) arst <= 0;
        nx(1);
        chk(19'({oalm, drv.pos_err_clear}), 19'h1);
    endtask

    initial begin
        i_clk = 0;
        forever #12.5 i_clk = ~i_clk;
    end
    initial begin
        #(60000 * 25);
        n_errors++;
        finish_test();
    end
    initial begin
        {i_rst, son, mok, alm, imm, arst, push} = 7'h70;
        cmd = 16'h0064;
        lim = 28'h00000c8;
        cfg = '0;
        cfg.undervoltage_trip_select = 1;
        cfg.mains_loss_hold_time = 11'h046;
        cfg.immediate_stop_torque_limit = 10'h12c;
        repeat (4) @(posedge i_clk);
        nx(1);
        cd(RUN, PR, 0, 0);
        chk(19'({oalm, ouv, oov, olost}), 0);
        @(posedge i_clk) i_rst <= 0;
        for (int s = 0; s < 10; s++) begin
            @(posedge i_clk);
            cfg.servo_off_stop_select <= 4'(s);
            son <= 0;
            nx(2);
            cd(s > 7 ? IM : s % 2 ? FR : DB, PD, s < 4 || s > 7, s inside {[4:7]});
            if (s > 7) chk(19'({drv.torque_lim_en, drv.torque_lim}), 19'h0052c);
            wph(PA);
            cd((s == 9 || (s < 8 && s[1])) ? FR : DB, PA, s < 4 || s > 7, s inside {[4:7]});
            @(posedge i_clk) push <= 1;
            @(posedge i_clk) push <= 0;
            nx(3);
            chk(19'(drv.phase), 19'(PA));
            if (s == 6) begin
                @(posedge i_clk) lim <= 28'h0000032;
                nx(2);
                chk(19'({oov, oalm}), 19'h3);
                @(posedge i_clk) lim <= 28'h00000c8;
                rs();
            end
            @(posedge i_clk) son <= 1;
            nx(2);
            cd(RUN, PR, 0, 0);
        end
        for (int f = 0; f < 8; f++) begin
            @(posedge i_clk);
            cfg.fault_stop_select <= 3'(f);
            cfg.servo_off_stop_select <= 4'h8;
            son <= (f % 2 == 0);
            al(f[0] ^ f[1]);
            nx(2);
            cd((f > 3 && (f[0] ^ f[1])) ? IM : f % 2 ? FR : DB, PD, 0, 1);
            wph(PA);
            cd(f[1] ? FR : DB, PA, 0, 1);
            rs();
            @(posedge i_clk) son <= 1;
            nx(2);
            cd(RUN, PR, 0, 0);
        end
        @(posedge i_clk) mok <= 0;
        wl();
        chk(19'(n >= 690 && n <= 720), 1);
        chk(19'({ouv, oalm}), 19'h3);
        @(posedge i_clk) mok <= 1;
        nx(5);
        rs();
        chk(19'(ouv), 0);
        @(posedge i_clk);
        cfg.undervoltage_trip_select <= 0;
        cfg.mains_off_stop_select <= 4'h3;
        cfg.fault_stop_select <= 3'h0;
        mok <= 0;
        wl();
        nx(1);
        cd(FR, PD, 1, 0);
        chk(19'({ouv, oalm}), 0);
        al(0);
        nx(2);
        cd(DB, PD, 0, 1);
        rs();
        @(posedge i_clk) mok <= 1;
        nx(6);
        cd(RUN, PR, 0, 0);
        // mains loss while the servo is already off: mains-off selection, no trip
        @(posedge i_clk);
        cfg.undervoltage_trip_select <= 1;
        cfg.mains_off_stop_select <= 4'h4;
        son <= 0;
        nx(12);
        @(posedge i_clk) mok <= 0;
        wl();
        cd(DB, PD, 0, 1);
        chk(19'({ouv, oalm}), 0);
        @(posedge i_clk);
        mok <= 1;
        son <= 1;
        nx(6);
        cd(RUN, PR, 0, 0);
        @(posedge i_clk);
        cfg.mains_loss_hold_time <= 11'h7d0;
        mok <= 0;
        nx(21000);
        chk(19'(olost), 0);
        finish_test();
    end
endmodule // tb
